// file: qpif_core_view.v
/*
 * One core's view of the pad events: masked status and interrupt level.
 * Assumes raw events come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qpif_map.vh"
module qpif_core_view #(
  parameter EVT_W = `QPIF_EVT_W
) (
  input wire [EVT_W-1:0] rawEvents,
  input wire [EVT_W-1:0] enMask,
  input wire [EVT_W-1:0] forceBits,
  output wire [EVT_W-1:0] maskedStatus,
  output wire irqLevel
);
  // force wins over both the raw event and the enable
  assign maskedStatus = (rawEvents & enMask) | forceBits;
  assign irqLevel = |maskedStatus;
endmodule
`default_nettype wire

// file: qpif_irq_checker.sv
/*
 Port-level checker for the pad interrupt block.
 Assumes binding to the top module with rst synchronous, active high.
*/
`timescale 1ns/1ps
`default_nettype none
module qpif_irq_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic [23:0] rawPadEvents,
  input wire logic irqFirstCore,
  input wire logic irqSecondCore,
  input wire logic irqNote
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rst_clear_a: assert property ($fell(rst) |-> regRdData == 32'h0 && !irqFirstCore && !irqSecondCore)
    else $error("outputs not cleared by reset");
  rsvd_bits_a: assert property (regRdData[31:24] == 8'h00)
    else $error("upper read bits not zero");
  force0_irq_a: assert property ((clkEn && regWrEn && regAddr == 8'h38 && regWrData[23:0] != 24'h0) ##1 clkEn |=> irqFirstCore)
    else $error("first core force gave no interrupt");
  force1_irq_a: assert property ((clkEn && regWrEn && regAddr == 8'h44 && regWrData[23:0] != 24'h0) ##1 clkEn |=> irqSecondCore)
    else $error("second core force gave no interrupt");
  stat0_irq_a: assert property (clkEn && regRdEn && regAddr == 8'h3C |=> irqFirstCore == (regRdData[23:0] != 24'h0))
    else $error("first core interrupt disagrees with status");
  stat1_irq_a: assert property (clkEn && regRdEn && regAddr == 8'h48 |=> irqSecondCore == (regRdData[23:0] != 24'h0))
    else $error("second core interrupt disagrees with status");
  mask0_zero_a: assert property ((clkEn && regWrEn && regAddr == 8'h34 && regWrData[23:0] == 24'h0) ##1 (clkEn && regWrEn && regAddr == 8'h38 && regWrData[23:0] == 24'h0) ##1 clkEn |=> !irqFirstCore)
    else $error("first core interrupt with mask and force clear");
  mask1_zero_a: assert property ((clkEn && regWrEn && regAddr == 8'h40 && regWrData[23:0] == 24'h0) ##1 (clkEn && regWrEn && regAddr == 8'h44 && regWrData[23:0] == 24'h0) ##1 clkEn |=> !irqSecondCore)
    else $error("second core interrupt with mask and force clear");
endmodule
`default_nettype wire

// file: qpif_irq_top.v
/*
 * Flash-pad interrupt enable, force and masked status for two cores,
 * with a register port and a notification interrupt.
 * Assumes raw pad events are already latched by logic on clk, and
 * that the register master never strobes read and write together.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "qpif_map.vh"

// Summary of operation
// - first core status is raw&enable or force
// - first core force: 24 bits, reset zero
// - second core enable: 24 bits, reset zero
// - second core force: 24 bits, reset zero
// - first core enable: 24 bits, reset zero
// - second core status formed like first core
module qpif_irq_top #(
  parameter ADDR_W = `QPIF_ADDR_W,
  parameter DATA_W = `QPIF_DATA_W,
  parameter EVT_W = `QPIF_EVT_W
) (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire [ADDR_W-1:0] regAddr,
  input wire [DATA_W-1:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [DATA_W-1:0] regRdData,
  input wire [EVT_W-1:0] rawPadEvents,
  output reg irqFirstCore,
  output reg irqSecondCore,
  output wire irqNote
);

  // address decode, shared by the write and the read paths
  function hitOffset;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] offset;
    begin
      hitOffset = (addr == offset);
    end
  endfunction

  // widen an event word to the bus, upper bits read as zero
  function [DATA_W-1:0] evtWord;
    input [EVT_W-1:0] evt;
    begin
      evtWord = {`QPIF_RSVD_HI, evt};
    end
  endfunction

  // register file state
  reg [EVT_W-1:0] core0Mask_r;
  reg [EVT_W-1:0] core0Force_r;
  reg [EVT_W-1:0] core1Mask_r;
  reg [EVT_W-1:0] core1Force_r;
  reg [`QPIF_NOTE_W-1:0] noteMask_r;
  reg [`QPIF_NOTE_W-1:0] irqPrev_r;

  wire wrCore0Mask;
  wire wrCore0Force;
  wire wrCore1Mask;
  wire wrCore1Force;
  wire wrNoteMask;
  wire rdNoteStat;

  wire [EVT_W-1:0] core0Status;
  wire [EVT_W-1:0] core1Status;
  wire core0Level;
  wire core1Level;
  wire [`QPIF_NOTE_W-1:0] irqNow;
  wire [`QPIF_NOTE_W-1:0] irqRise;
  wire [`QPIF_NOTE_W-1:0] noteStat;
  reg [DATA_W-1:0] rdData_nxt;

  assign wrCore0Mask = regWrEn & hitOffset(regAddr, `QPIF_OFF_CORE0_MASK);
  assign wrCore0Force = regWrEn & hitOffset(regAddr, `QPIF_OFF_CORE0_FORCE);
  assign wrCore1Mask = regWrEn & hitOffset(regAddr, `QPIF_OFF_CORE1_MASK);
  assign wrCore1Force = regWrEn & hitOffset(regAddr, `QPIF_OFF_CORE1_FORCE);
  assign wrNoteMask = regWrEn & hitOffset(regAddr, `QPIF_OFF_NOTE_MASK);
  // a read of the notification status clears it
  assign rdNoteStat = regRdEn & hitOffset(regAddr, `QPIF_OFF_NOTE_STAT);

  // first core enable
  always @(posedge clk) begin
    if (rst) begin
      core0Mask_r <= `QPIF_RST_EVT;
    end else if (clkEn && wrCore0Mask) begin
      core0Mask_r <= regWrData[EVT_W-1:0];
    end
  end

  // first core force
  always @(posedge clk) begin
    if (rst) begin
      core0Force_r <= `QPIF_RST_EVT;
    end else if (clkEn && wrCore0Force) begin
      core0Force_r <= regWrData[EVT_W-1:0];
    end
  end

  // second core enable
  always @(posedge clk) begin
    if (rst) begin
      core1Mask_r <= `QPIF_RST_EVT;
    end else if (clkEn && wrCore1Mask) begin
      core1Mask_r <= regWrData[EVT_W-1:0];
    end
  end

  // second core force
  always @(posedge clk) begin
    if (rst) begin
      core1Force_r <= `QPIF_RST_EVT;
    end else if (clkEn && wrCore1Force) begin
      core1Force_r <= regWrData[EVT_W-1:0];
    end
  end

  // notification mask
  always @(posedge clk) begin
    if (rst) begin
      noteMask_r <= `QPIF_NOTE_RST;
    end else if (clkEn && wrNoteMask) begin
      noteMask_r <= regWrData[`QPIF_NOTE_W-1:0];
    end
  end

  // per-core masking and forcing
  qpif_core_view #(
    .EVT_W(EVT_W)
  ) firstCoreView (
    .rawEvents(rawPadEvents),
    .enMask(core0Mask_r),
    .forceBits(core0Force_r),
    .maskedStatus(core0Status),
    .irqLevel(core0Level)
  );

  qpif_core_view #(
    .EVT_W(EVT_W)
  ) secondCoreView (
    .rawEvents(rawPadEvents),
    .enMask(core1Mask_r),
    .forceBits(core1Force_r),
    .maskedStatus(core1Status),
    .irqLevel(core1Level)
  );

  // core lines registered so they are glitch free toward the cores
  always @(posedge clk) begin
    if (rst) begin
      irqFirstCore <= 1'b0;
      irqSecondCore <= 1'b0;
    end else if (clkEn) begin
      irqFirstCore <= core0Level;
      irqSecondCore <= core1Level;
    end
  end

  // rising edge of each core line is a notification event
  assign irqNow[`QPIF_NOTE_CORE0] = core0Level;
  assign irqNow[`QPIF_NOTE_CORE1] = core1Level;

  always @(posedge clk) begin
    if (rst) begin
      irqPrev_r <= `QPIF_NOTE_RST;
    end else if (clkEn) begin
      irqPrev_r <= irqNow;
    end
  end

  assign irqRise = irqNow & ~irqPrev_r;

  qpif_sticky_note #(
    .W(`QPIF_NOTE_W)
  ) noteBits (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .setPulse(irqRise),
    .clearAll(rdNoteStat),
    .sticky_r(noteStat)
  );

  assign irqNote = |(noteStat & noteMask_r);

  // read mux; unmapped offsets read as zero
  always @* begin
    rdData_nxt = `QPIF_RST_WORD;
    if (hitOffset(regAddr, `QPIF_OFF_CORE0_MASK)) begin
      rdData_nxt = evtWord(core0Mask_r);
    end else if (hitOffset(regAddr, `QPIF_OFF_CORE0_FORCE)) begin
      rdData_nxt = evtWord(core0Force_r);
    end else if (hitOffset(regAddr, `QPIF_OFF_CORE0_STAT)) begin
      rdData_nxt = evtWord(core0Status);
    end else if (hitOffset(regAddr, `QPIF_OFF_CORE1_MASK)) begin
      rdData_nxt = evtWord(core1Mask_r);
    end else if (hitOffset(regAddr, `QPIF_OFF_CORE1_FORCE)) begin
      rdData_nxt = evtWord(core1Force_r);
    end else if (hitOffset(regAddr, `QPIF_OFF_CORE1_STAT)) begin
      rdData_nxt = evtWord(core1Status);
    end else if (hitOffset(regAddr, `QPIF_OFF_NOTE_STAT)) begin
      rdData_nxt = {{(DATA_W-`QPIF_NOTE_W){1'b0}}, noteStat};
    end else if (hitOffset(regAddr, `QPIF_OFF_NOTE_MASK)) begin
      rdData_nxt = {{(DATA_W-`QPIF_NOTE_W){1'b0}}, noteMask_r};
    end
  end

  // data valid only the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (rst) begin
      regRdData <= `QPIF_RST_WORD;
    end else if (clkEn) begin
      if (regRdEn) begin
        regRdData <= rdData_nxt;
      end else begin
        regRdData <= `QPIF_RST_WORD;
      end
    end
  end

endmodule
`default_nettype wire

// file: qpif_map.vh
/*
 * Register map, field layout and reset values for the flash-pad
 * interrupt force and masked-status block.
 * Assumes an 8-bit byte address on a plain strobe register port.
 */
`ifndef QPIF_MAP_VH
`define QPIF_MAP_VH

`define QPIF_ADDR_W 8
`define QPIF_DATA_W 32
`define QPIF_EVT_W 24

// byte offsets of the word registers
`define QPIF_OFF_CORE0_MASK 8'h34
`define QPIF_OFF_CORE0_FORCE 8'h38
`define QPIF_OFF_CORE0_STAT 8'h3C
`define QPIF_OFF_CORE1_MASK 8'h40
`define QPIF_OFF_CORE1_FORCE 8'h44
`define QPIF_OFF_CORE1_STAT 8'h48
`define QPIF_OFF_NOTE_STAT 8'h60
`define QPIF_OFF_NOTE_MASK 8'h64

`define QPIF_RST_EVT 24'h000000
`define QPIF_RST_WORD 32'h00000000
`define QPIF_RSVD_HI 8'h00

// four events per pad, lowest pad first
`define QPIF_PAD_SCLK 0
`define QPIF_PAD_SS 1
`define QPIF_PAD_DATA0 2
`define QPIF_PAD_CNT 6
`define QPIF_EVT_PER_PAD 4
`define QPIF_EVT_LVL_LOW 0
`define QPIF_EVT_LVL_HIGH 1
`define QPIF_EVT_EDGE_LOW 2
`define QPIF_EVT_EDGE_HIGH 3

// notification status/mask layout
`define QPIF_NOTE_W 2
`define QPIF_NOTE_CORE0 0
`define QPIF_NOTE_CORE1 1
`define QPIF_NOTE_RST 2'h0

`endif

// file: qpif_pad_events.sv
/*
 Pad event source standing in for the raw event latches.
 Assumes the bench changes its inputs just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module qpif_pad_events (
  input wire logic [2:0] padSel,
  input wire logic [1:0] kindSel,
  input wire logic fire,
  output logic [23:0] rawPadEvents
);
  // one event at a time so a wrong bit lane cannot hide
  assign rawPadEvents = fire ? (24'h000001 << {padSel, kindSel}) : 24'h000000;
endmodule
`default_nettype wire

// file: qpif_sticky_note.v
/*
 * Sticky event bits cleared by a read; a set in the clearing cycle wins.
 * Assumes pulse events and a read strobe on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "qpif_map.vh"
module qpif_sticky_note #(
  parameter W = `QPIF_NOTE_W
) (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire [W-1:0] setPulse,
  input wire clearAll,
  output reg [W-1:0] sticky_r
);
  reg [W-1:0] sticky_nxt;

  always @* begin
    sticky_nxt = sticky_r;
    if (clearAll) begin
      sticky_nxt = {W{1'b0}};
    end
    sticky_nxt = sticky_nxt | setPulse;
  end

  always @(posedge clk) begin
    if (rst) begin
      sticky_r <= {W{1'b0}};
    end else if (clkEn) begin
      sticky_r <= sticky_nxt;
    end
  end
endmodule
`default_nettype wire

// file: test_qspi_pad_irq_force_status.sv
/*
 Self-checking bench for the pad interrupt block over its register port.
 Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_qspi_pad_irq_force_status;
  logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, fire = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, bitV;
  logic [2:0] padSel = 3'h0;
  logic [1:0] kindSel = 2'h0;
  logic [7:0] regList [6] = '{8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48};
  wire [31:0] regRdData;
  wire [23:0] rawPadEvents;
  wire irqFirstCore, irqSecondCore, irqNote;
  int badCount = 0, checksDone = 0, i;
  always #25 clk = ~clk;
  qpif_irq_top DUT (.clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .rawPadEvents(rawPadEvents), .irqFirstCore(irqFirstCore),
    .irqSecondCore(irqSecondCore), .irqNote(irqNote));
  qpif_pad_events PADS (.padSel(padSel), .kindSel(kindSel), .fire(fire),
    .rawPadEvents(rawPadEvents));
  task stopTest;
    if (badCount == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // drives just after an edge; strobes stay up only for the next edge
  task acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    regWrEn <= w;
    regRdEn <= r;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    acc(1'b0, 1'b1, a, 32'h0);
    chk(regRdData, exp, nm);
  endtask
  initial begin
    #100us;
    badCount++;
    stopTest;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    for (i = 0; i < 6; i++) begin
      rd(regList[i], 32'h0, "reset value");
    end
    rd(8'h70, 32'h0, "unmapped read");
    acc(1'b1, 1'b0, 8'h38, 32'hFFFFFFFF);
    rd(8'h38, 32'h00FFFFFF, "core0 force");
    rd(8'h3C, 32'h00FFFFFF, "core0 forced status");
    chk({31'h0, irqFirstCore}, 32'h1, "core0 irq forced");
    acc(1'b1, 1'b0, 8'h3C, 32'h0);
    rd(8'h3C, 32'h00FFFFFF, "status write ignored");
    acc(1'b1, 1'b0, 8'h34, 32'h0);
    acc(1'b1, 1'b0, 8'h38, 32'h0);
    acc(1'b1, 1'b0, 8'h40, 32'h0);
    acc(1'b1, 1'b0, 8'h44, 32'h0);
    acc(1'b0, 1'b0, 8'h00, 32'h0);
    chk({30'h0, irqSecondCore, irqFirstCore}, 32'h0, "irqs idle");
    for (i = 0; i < 24; i++) begin
      bitV = 32'h1 << i;
      padSel <= 3'(i / 4);
      kindSel <= 2'(i % 4);
      fire <= 1'b1;
      acc(1'b1, 1'b0, 8'h34, bitV);
      acc(1'b1, 1'b0, 8'h40, ~bitV & 32'h00FFFFFF);
      rd(8'h3C, bitV, "core0 event");
      rd(8'h48, 32'h0, "core1 gated");
      chk({31'h0, irqFirstCore}, 32'h1, "core0 irq");
      acc(1'b1, 1'b0, 8'h44, bitV);
      rd(8'h48, bitV, "core1 force");
      chk({31'h0, irqSecondCore}, 32'h1, "core1 irq");
      acc(1'b1, 1'b0, 8'h44, 32'h0);
    end
    fire <= 1'b0;
    acc(1'b1, 1'b0, 8'h34, 32'h0);
    chk({31'h0, irqNote}, 32'h0, "note masked");
    rd(8'h60, 32'h3, "note status");
    acc(1'b1, 1'b0, 8'h64, 32'h1);
    acc(1'b1, 1'b0, 8'h38, 32'h1);
    acc(1'b0, 1'b0, 8'h00, 32'h0);
    chk({31'h0, irqNote}, 32'h1, "note raised");
    rd(8'h60, 32'h1, "note status core0");
    chk({31'h0, irqNote}, 32'h0, "note cleared");
    // a write while the enable is low must be lost
    clkEn <= 1'b0;
    acc(1'b1, 1'b0, 8'h44, 32'h1);
    clkEn <= 1'b1;
    rd(8'h44, 32'h0, "write frozen by enable");
    rd(8'h38, 32'h1, "core0 force kept");
    acc(1'b0, 1'b0, 8'h00, 32'h0);
    chk(regRdData, 32'h0, "read data dropped");
    // mid-run reset clears what was written
    rst <= 1'b1;
    acc(1'b0, 1'b0, 8'h00, 32'h0);
    rst <= 1'b0;
    rd(8'h38, 32'h0, "core0 force after reset");
    rd(8'h64, 32'h0, "note mask after reset");
    chk({30'h0, irqSecondCore, irqFirstCore}, 32'h0, "irqs after reset");
    stopTest;
  end
endmodule
bind qpif_irq_top qpif_irq_checker CHK (.clk(clk), .rst(rst), .clkEn(clkEn),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .rawPadEvents(rawPadEvents), .irqFirstCore(irqFirstCore),
  .irqSecondCore(irqSecondCore), .irqNote(irqNote));
`default_nettype wire
